//--- hw/qa_wd_pkg.sv
// Constants and types for the multi-answer watchdog evaluation
package qa_wd_pkg;
  localparam logic       STYLE_MULTI     = 1'b0;
  localparam logic [1:0] TALLY_INIT_MULTI  = 2'h3;
  localparam logic [1:0] TALLY_INIT_SINGLE = 2'h1;
  localparam logic [2:0] WIN1_NEEDED     = 3'h3;
  localparam logic [2:0] CYCLE_ANSWERS   = 3'h4;
  localparam logic [3:0] FLAG_WRONG_BIT  = 4'h1;
  localparam logic [3:0] FLAG_EARLY_BIT  = 4'h2;
  localparam logic [3:0] FLAG_ORDER_BIT  = 4'h4;
  localparam logic [3:0] FLAG_EXPIRY_BIT = 4'h8;
  typedef enum logic [1:0] {ST_IDLE, ST_WIN1, ST_WIN2} phase_t;
endpackage

//--- hw/qa_wd_judge.sv
// Combinational verdict of one finished multi-answer cycle
`timescale 1ns/10ps
module qa_wd_judge (
  input  wire logic [2:0] i_w1_ok,
  input  wire logic [2:0] i_w1_bad,
  input  wire logic [2:0] i_w2_ok,
  input  wire logic [2:0] i_w2_bad,
  output logic      [3:0] o_flags,
  output logic            o_pass
);
  logic [2:0] w1_n;
  logic [2:0] w2_n;
  logic [3:0] tot;
  logic       any_bad;
  always_comb begin
    w1_n    = i_w1_ok + i_w1_bad;
    w2_n    = i_w2_ok + i_w2_bad;
    tot     = {1'b0, w1_n} + {1'b0, w2_n};
    any_bad = (i_w1_bad != 3'h0) || (i_w2_bad != 3'h0);
    o_flags = 4'h0;
    if (w1_n >= qa_wd_pkg::CYCLE_ANSWERS) begin
      o_flags = qa_wd_pkg::FLAG_EARLY_BIT;
    end else if (w1_n == qa_wd_pkg::WIN1_NEEDED) begin
      if (w2_n == 3'h0) begin
        o_flags = qa_wd_pkg::FLAG_EXPIRY_BIT;
      end
    end else begin
      o_flags = qa_wd_pkg::FLAG_ORDER_BIT;
      if (tot < {1'b0, qa_wd_pkg::CYCLE_ANSWERS}) begin
        o_flags = o_flags | qa_wd_pkg::FLAG_EXPIRY_BIT;
      end
    end
    if (any_bad) begin
      o_flags = o_flags | qa_wd_pkg::FLAG_WRONG_BIT;
    end
    o_pass = (o_flags == 4'h0);
  end
endmodule

//--- hw/qa_watchdog_multi_answer_eval.sv
// Multi-answer watchdog cycle evaluation with flags and failure counter steps
`timescale 1ns/10ps
module qa_watchdog_multi_answer_eval #(
  parameter int FAIL_W = 4
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  input  wire logic              i_qa_style_select,
  input  wire logic              i_init,
  input  wire logic              i_cycle_start,
  input  wire logic              i_win1_end,
  input  wire logic              i_win2_end,
  input  wire logic              i_answer_valid,
  input  wire logic              i_answer_ok,
  input  wire logic              i_state_word_read,
  output logic                   o_wrong_answer_flag,
  output logic                   o_premature_answer_flag,
  output logic                   o_order_fault_flag,
  output logic                   o_expiry_flag,
  output logic                   o_cycle_done,
  output logic                   o_fail_inc,
  output logic                   o_fail_dec,
  output logic                   o_new_question,
  output logic       [1:0]       o_reply_tally
);
  typedef struct packed {
    qa_wd_pkg::phase_t phase;
    logic [2:0] w1_ok;
    logic [2:0] w1_bad;
    logic [2:0] w2_ok;
    logic [2:0] w2_bad;
    logic [3:0] flags;
    logic       done;
    logic       inc;
    logic       dec;
    logic       newq;
    logic [1:0] tally;
  } state_t;

  state_t     s_r;
  state_t     s_nxt;
  logic [3:0] verdict_flags;
  logic       verdict_pass;
  logic [2:0] w1_n;
  logic [3:0] tot;
  logic       end_now;
  logic       multi;
  logic [2:0] c_w1_ok;
  logic [2:0] c_w1_bad;
  logic [2:0] c_w2_ok;
  logic [2:0] c_w2_bad;

  qa_wd_judge u_judge (
    .i_w1_ok  (c_w1_ok),
    .i_w1_bad (c_w1_bad),
    .i_w2_ok  (c_w2_ok),
    .i_w2_bad (c_w2_bad),
    .o_flags  (verdict_flags),
    .o_pass   (verdict_pass)
  );

  // Judge reads these, not s_nxt, so clearing counts cannot feed back
  always_comb begin
    c_w1_ok  = s_r.w1_ok;
    c_w1_bad = s_r.w1_bad;
    c_w2_ok  = s_r.w2_ok;
    c_w2_bad = s_r.w2_bad;
    if (i_answer_valid && (s_r.phase == qa_wd_pkg::ST_WIN1)) begin
      if (i_answer_ok) begin
        c_w1_ok = s_r.w1_ok + 3'h1;
      end else begin
        c_w1_bad = s_r.w1_bad + 3'h1;
      end
    end
    if (i_answer_valid && (s_r.phase == qa_wd_pkg::ST_WIN2)) begin
      if (i_answer_ok) begin
        c_w2_ok = s_r.w2_ok + 3'h1;
      end else begin
        c_w2_bad = s_r.w2_bad + 3'h1;
      end
    end
  end

  assign multi = (i_qa_style_select == qa_wd_pkg::STYLE_MULTI);

  // Count first, then decide; the judge sees the counts including this answer
  always_comb begin
    s_nxt        = s_r;
    s_nxt.done   = 1'b0;
    s_nxt.inc    = 1'b0;
    s_nxt.dec    = 1'b0;
    s_nxt.newq   = 1'b0;
    end_now      = 1'b0;
    w1_n         = s_r.w1_ok + s_r.w1_bad;
    tot          = 4'h0;
    if (i_state_word_read) begin
      s_nxt.flags = 4'h0;
    end
    unique case (s_r.phase)
      qa_wd_pkg::ST_IDLE: begin
        if (i_cycle_start && multi) begin
          s_nxt.phase = qa_wd_pkg::ST_WIN1;
        end
      end
      qa_wd_pkg::ST_WIN1: begin
        if (i_answer_valid) begin
          s_nxt.w1_ok  = c_w1_ok;
          s_nxt.w1_bad = c_w1_bad;
          end_now = (w1_n + 3'h1 == qa_wd_pkg::CYCLE_ANSWERS);
        end else if (i_win1_end) begin
          s_nxt.phase = qa_wd_pkg::ST_WIN2;
        end
      end
      qa_wd_pkg::ST_WIN2: begin
        tot = {1'b0, w1_n} + {1'b0, s_r.w2_ok + s_r.w2_bad};
        if (i_answer_valid) begin
          s_nxt.w2_ok  = c_w2_ok;
          s_nxt.w2_bad = c_w2_bad;
          end_now = (tot + 4'h1 == {1'b0, qa_wd_pkg::CYCLE_ANSWERS});
        end else if (i_win2_end) begin
          end_now = 1'b1;
        end
      end
      default: s_nxt.phase = qa_wd_pkg::ST_IDLE;
    endcase
    if (end_now) begin
      // Cycle end flags overwrite a same-cycle read clear
      s_nxt.flags  = verdict_flags;
      s_nxt.done   = 1'b1;
      s_nxt.dec    = verdict_pass;
      s_nxt.newq   = verdict_pass;
      s_nxt.inc    = !verdict_pass;
      s_nxt.w1_ok  = 3'h0;
      s_nxt.w1_bad = 3'h0;
      s_nxt.w2_ok  = 3'h0;
      s_nxt.w2_bad = 3'h0;
      s_nxt.phase  = multi ? qa_wd_pkg::ST_WIN1 : qa_wd_pkg::ST_IDLE;
    end
    if (i_init) begin
      s_nxt.phase  = qa_wd_pkg::ST_IDLE;
      s_nxt.w1_ok  = 3'h0;
      s_nxt.w1_bad = 3'h0;
      s_nxt.w2_ok  = 3'h0;
      s_nxt.w2_bad = 3'h0;
      s_nxt.flags  = 4'h0;
      s_nxt.tally  = multi ? qa_wd_pkg::TALLY_INIT_MULTI
                           : qa_wd_pkg::TALLY_INIT_SINGLE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s_r       <= '0;
      s_r.tally <= qa_wd_pkg::TALLY_INIT_MULTI;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_wrong_answer_flag     = s_r.flags[0];
  assign o_premature_answer_flag = s_r.flags[1];
  assign o_order_fault_flag      = s_r.flags[2];
  assign o_expiry_flag           = s_r.flags[3];
  assign o_cycle_done            = s_r.done;
  assign o_fail_inc              = s_r.inc;
  assign o_fail_dec              = s_r.dec;
  assign o_new_question          = s_r.newq;
  assign o_reply_tally           = s_r.tally;

  property p_pass_or_fail;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_cycle_done |-> (o_fail_inc != o_fail_dec);
  endproperty
  a_pass_or_fail: assert property (p_pass_or_fail)
    else $error("cycle end without exactly one counter step");

  property p_pass_clean;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_fail_dec |-> (s_r.flags == 4'h0) && o_new_question;
  endproperty
  a_pass_clean: assert property (p_pass_clean)
    else $error("passing cycle left flags or no new question");

  property p_fail_same_q;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_fail_inc |-> !o_new_question && (s_r.flags != 4'h0);
  endproperty
  a_fail_same_q: assert property (p_fail_same_q)
    else $error("failing cycle gave a new question");

  property p_early_alone;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_cycle_done && o_premature_answer_flag |->
        !o_order_fault_flag && !o_expiry_flag;
  endproperty
  a_early_alone: assert property (p_early_alone)
    else $error("premature flag with order or expiry flag");

  property p_win2_close;
    @(posedge i_sys_clk) disable iff (i_reset || i_init)
      (s_r.phase == qa_wd_pkg::ST_WIN2) && i_win2_end && !i_answer_valid
        |=> o_cycle_done && o_expiry_flag;
  endproperty
  a_win2_close: assert property (p_win2_close)
    else $error("window two close did not end cycle with expiry");

  property p_read_clears;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_state_word_read && !end_now && !i_init |=> s_r.flags == 4'h0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear flags");

  property p_init_tally;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_init && multi |=> o_reply_tally == 2'h3;
  endproperty
  a_init_tally: assert property (p_init_tally)
    else $error("tally not loaded with three in multi-answer mode");

  property p_single_idle;
    @(posedge i_sys_clk) disable iff (i_reset)
      !multi && (s_r.phase == qa_wd_pkg::ST_IDLE) |=> !o_cycle_done;
  endproperty
  a_single_idle: assert property (p_single_idle)
    else $error("cycle evaluated outside multi-answer mode");
endmodule

//--- verification/qa_host_model.sv
// Host-side answer source for the watchdog evaluation bench
`timescale 1ns/10ps
module qa_host_model (
  input  wire logic i_sys_clk,
  output logic      o_answer_valid,
  output logic      o_answer_ok
);
  initial begin
    o_answer_valid = 1'b0;
    o_answer_ok    = 1'b0;
  end
  // One answer a call, in any phase; the task does not wait for a window
  task automatic answer(input logic ok);
    @(negedge i_sys_clk);
    o_answer_valid = 1'b1;
    o_answer_ok    = ok;
    @(negedge i_sys_clk);
    o_answer_valid = 1'b0;
    // Stale line shows the inverse, never a held value
    o_answer_ok    = ~ok;
  endtask
endmodule

//--- verification/qa_watchdog_multi_answer_eval_bench.sv
// Scenario bench for the multi-answer watchdog evaluation
`timescale 1ns/10ps
module qa_watchdog_multi_answer_eval_bench;
  logic       clk, rst, sel, av, aok;
  logic [4:0] ev;
  logic       wr, er, od, ex, dn, fi, fd, nq;
  logic [1:0] tly;
  int         n_errors, checks_done;

  qa_host_model h (.i_sys_clk(clk), .o_answer_valid(av), .o_answer_ok(aok));
  qa_watchdog_multi_answer_eval uut (
    .i_sys_clk(clk), .i_reset(rst), .i_qa_style_select(sel),
    .i_init(ev[4]), .i_cycle_start(ev[0]), .i_win1_end(ev[1]),
    .i_win2_end(ev[2]), .i_answer_valid(av), .i_answer_ok(aok),
    .i_state_word_read(ev[3]), .o_wrong_answer_flag(wr),
    .o_premature_answer_flag(er), .o_order_fault_flag(od),
    .o_expiry_flag(ex), .o_cycle_done(dn), .o_fail_inc(fi),
    .o_fail_dec(fd), .o_new_question(nq), .o_reply_tally(tly));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input int k);
    @(negedge clk);
    ev[k] = 1'b1;
    @(negedge clk);
    ev[k] = 1'b0;
  endtask

  // Masks: bit i set means answer i is correct
  task automatic cyc(input int n1, n2, input logic [3:0] m1, m2, ef);
    int   i;
    logic p;
    p = (ef == 4'h0);
    for (i = 0; i < n1; i++) h.answer(m1[i]);
    // Four answers in window one end the cycle on their own
    if (n1 < 4) begin
      pulse(1);
      for (i = 0; i < n2; i++) h.answer(m2[i]);
      if (n1 + n2 < 4) pulse(2);
    end
    for (i = 0; i < 9 && dn !== 1'b1; i++) @(negedge clk);
    if (dn !== 1'b1) begin
      n_errors++;
      complete_run();
    end
    chk({wr, er, od, ex}, ef);
    chk({1'b0, fd, fi, nq}, {1'b0, p, !p, p});
  endtask

  task automatic sc_pass;
    cyc(3, 1, 4'h7, 4'h1, 4'h0);
  endtask
  task automatic sc_late_wrong;
    cyc(3, 1, 4'h7, 4'h0, 4'h8);
    cyc(3, 1, 4'h0, 4'h1, 4'h8);
  endtask
  task automatic sc_expiry;
    cyc(3, 0, 4'h7, 4'h0, 4'h1);
    cyc(3, 0, 4'h0, 4'h0, 4'h9);
  endtask
  task automatic sc_early;
    cyc(4, 0, 4'hf, 4'h0, 4'h4);
    cyc(4, 0, 4'h5, 4'h0, 4'hc);
  endtask
  task automatic sc_order;
    cyc(1, 3, 4'h1, 4'h7, 4'h2);
    cyc(1, 3, 4'h0, 4'h7, 4'ha);
    cyc(2, 1, 4'h3, 4'h1, 4'h3);
    cyc(1, 1, 4'h0, 4'h1, 4'hb);
    cyc(1, 0, 4'h1, 4'h0, 4'h3);
    cyc(0, 0, 4'h0, 4'h0, 4'h3);
  endtask
  task automatic sc_read;
    pulse(3);
    chk({wr, er, od, ex}, 4'h0);
  endtask
  task automatic sc_init;
    sel = 1'b1;
    pulse(4);
    chk({2'b00, tly}, 4'h1);
    chk({wr, er, od, ex}, 4'h0);
    pulse(0);
    repeat (4) h.answer(1'b1);
    chk({3'b000, dn}, 4'h0);
    chk({wr, er, od, ex}, 4'h0);
    sel = 1'b0;
    pulse(4);
    chk({2'b00, tly}, 4'h3);
  endtask

  initial begin
    n_errors    = 0;
    checks_done = 0;
    rst = 1'b1;
    sel = 1'b0;
    ev  = 5'h00;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({2'b00, tly}, 4'h3);
    pulse(0);
    sc_pass();
    sc_late_wrong();
    sc_expiry();
    sc_early();
    sc_order();
    sc_read();
    sc_init();
    complete_run();
  end
endmodule
